//--- verilog/oaf_core.sv
// Purpose: Operand addressing, branch target and condition flag core.
// Assumes: Memory answers a read on memData in the cycle in which memRead is high.
// Notes:   Opcodes: 01dddsss move, 00dd d110 load immediate, 10ooosss alu,
//          11ooo110 alu immediate, 00pp0001 load pair, 00111010 load direct,
//          00110010 store direct, 000p1010 load indirect, 000p0010 store
//          indirect, 11000011 jump, 11101001 jump via pair, 11nnn111 restart.
`timescale 1ns/10ps
`default_nettype none
module oaf_core
  import oaf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  memData,
  output logic      [15:0] memAddr,
  output logic             memRead,
  output logic             memWrite,
  output logic      [7:0]  memWdata,
  output logic      [7:0]  flags,
  output logic      [15:0] pcValue,
  output logic      [15:0] spValue,
  output logic      [7:0]  accumulator,
  output logic             halted
);

  logic [7:0]    regs [0:7];
  logic [7:0]    next_regs [0:7];
  logic [15:0]   pc;
  logic [15:0]   next_pc;
  logic [15:0]   sp;
  logic [15:0]   next_sp;
  logic [7:0]    opcode;
  logic [7:0]    next_opcode;
  logic [7:0]    immLow;
  logic [7:0]    next_immLow;
  oaf_state_type state;
  oaf_state_type next_state;
  logic [7:0]    next_flags;
  logic [15:0]   next_memAddr;
  logic          next_memRead;
  logic          next_memWrite;
  logic [7:0]    next_memWdata;
  logic [7:0]    aluB;
  logic [7:0]    aluResult;
  logic [7:0]    aluFlags;
  logic          needTwo;
  logic          needOne;

  function automatic logic [15:0] pairValue(input logic [1:0] sel, input logic [15:0] spv,
                                            input logic [7:0] b, input logic [7:0] c,
                                            input logic [7:0] d, input logic [7:0] e,
                                            input logic [7:0] h, input logic [7:0] l);
    if (sel == PAIR_BC) begin
      pairValue = {b, c};
    end else if (sel == PAIR_DE) begin
      pairValue = {d, e};
    end else if (sel == PAIR_HL) begin
      pairValue = {h, l};
    end else begin
      pairValue = spv;
    end
  endfunction

  oaf_alu u_alu (
    .opA      (regs[REG_A]),
    .opB      (aluB),
    .aluOp    (oaf_alu_type'(opcode[5:3])),
    .carryIn  (flags[FLAG_CARRY]),
    .result   (aluResult),
    .flagsOut (aluFlags)
  );

  always_comb begin
    needTwo = (opcode[7:6] == 2'b00) && ((opcode[3:0] == 4'h1) ||
              (opcode[5:0] == 6'h3A) || (opcode[5:0] == 6'h32));
    needTwo = needTwo || (opcode == 8'hC3);
    needOne = ((opcode[7:6] == 2'b00) && (opcode[2:0] == 3'h6)) ||
              ((opcode[7:6] == 2'b11) && (opcode[2:0] == 3'h6));
    if (opcode[7:6] == 2'b10) begin
      aluB = (opcode[2:0] == REG_MEM) ? memData : regs[opcode[2:0]];
    end else begin
      aluB = immLow;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_regs[i] = regs[i];
    end
    next_pc = pc;
    next_sp = sp;
    next_opcode = opcode;
    next_immLow = immLow;
    next_state = state;
    next_flags = flags;
    next_memAddr = memAddr;
    next_memRead = 1'b0;
    next_memWrite = 1'b0;
    next_memWdata = memWdata;
    case (state)
      ST_FETCH: begin
        next_memAddr = pc;
        next_memRead = 1'b1;
        next_pc = pc + 16'h0001;
        next_state = ST_DECODE;
      end
      ST_DECODE: begin
        next_opcode = memData;
        next_state = ST_EXEC;
        if (memData == 8'h76) begin
          next_state = ST_HALT;
        end else if (((memData[7:6] == 2'b00) && ((memData[3:0] == 4'h1) ||
                     (memData[5:0] == 6'h3A) || (memData[5:0] == 6'h32))) ||
                     (memData == 8'hC3) ||
                     ((memData[7:6] != 2'b01) && (memData[7:6] != 2'b10) &&
                      (memData[2:0] == 3'h6))) begin
          next_memAddr = pc;
          next_memRead = 1'b1;
          next_pc = pc + 16'h0001;
          next_state = ST_IMM1;
        end else if (((memData[7:6] == 2'b01) && (memData[2:0] == REG_MEM)) ||
                     ((memData[7:6] == 2'b10) && (memData[2:0] == REG_MEM)) ||
                     ((memData[7:5] == 3'b000) && (memData[3:0] == 4'hA))) begin
          next_memAddr = (memData[7:6] == 2'b00) ?
            pairValue(memData[5:4], sp, regs[REG_B], regs[REG_C], regs[REG_D],
                      regs[REG_E], regs[REG_H], regs[REG_L]) : {regs[REG_H], regs[REG_L]};
          next_memRead = 1'b1;
          next_state = ST_MEMRD;
        end
      end
      ST_IMM1: begin
        next_immLow = memData;
        next_state = ST_EXEC;
        if (needTwo) begin
          next_memAddr = pc;
          next_memRead = 1'b1;
          next_pc = pc + 16'h0001;
          next_state = ST_IMM2;
        end else if (opcode[7:6] == 2'b00 && opcode[5:3] == REG_MEM) begin
          next_memAddr = {regs[REG_H], regs[REG_L]};
          next_memWdata = memData;
          next_memWrite = 1'b1;
          next_state = ST_FETCH;
        end
      end
      ST_IMM2: begin
        next_state = ST_FETCH;
        if (opcode == 8'hC3) begin
          next_pc = {memData, immLow};
        end else if (opcode[3:0] == 4'h1) begin
          if (opcode[5:4] == PAIR_SP) begin
            next_sp = {memData, immLow};
          end else begin
            next_regs[{opcode[5:4], 1'b0}] = memData;
            next_regs[{opcode[5:4], 1'b1}] = immLow;
          end
        end else if (opcode[5:0] == 6'h3A) begin
          next_memAddr = {memData, immLow};
          next_memRead = 1'b1;
          next_state = ST_MEMRD;
        end else begin
          next_memAddr = {memData, immLow};
          next_memWdata = regs[REG_A];
          next_memWrite = 1'b1;
        end
      end
      ST_MEMRD: begin
        // Read data stands only while the strobe is high, so it is taken here.
        next_state = ST_FETCH;
        if (opcode[7:6] == 2'b10) begin
          next_regs[REG_A] = (opcode[5:3] == 3'h7) ? regs[REG_A] : aluResult;
          next_flags = aluFlags;
        end else if (opcode[7:6] == 2'b01) begin
          next_regs[opcode[5:3]] = memData;
        end else begin
          next_regs[REG_A] = memData;
        end
      end
      ST_EXEC: begin
        next_state = ST_FETCH;
        if (opcode[7:6] == 2'b01) begin
          if (opcode[5:3] == REG_MEM) begin
            next_memAddr = {regs[REG_H], regs[REG_L]};
            next_memWdata = regs[opcode[2:0]];
            next_memWrite = 1'b1;
          end else begin
            next_regs[opcode[5:3]] = regs[opcode[2:0]];
          end
        end else if ((opcode[7:6] == 2'b10) || (opcode[7:6] == 2'b11 && needOne)) begin
          next_flags = aluFlags;
          if (opcode[5:3] != 3'h7) begin
            next_regs[REG_A] = aluResult;
          end
        end else if (opcode[7:6] == 2'b00 && needOne) begin
          next_regs[opcode[5:3]] = immLow;
        end else if ((opcode[7:5] == 3'b000) && (opcode[3:0] == 4'h2)) begin
          next_memAddr = pairValue(opcode[5:4], sp, regs[REG_B], regs[REG_C],
                                   regs[REG_D], regs[REG_E], regs[REG_H], regs[REG_L]);
          next_memWdata = regs[REG_A];
          next_memWrite = 1'b1;
        end else if (opcode == 8'hE9) begin
          next_pc = {regs[REG_H], regs[REG_L]};
        end else if ((opcode[7:6] == 2'b11) && (opcode[2:0] == 3'h7)) begin
          next_pc = {10'h000, opcode[5:3], 3'h0};
        end
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
      default: begin
        next_state = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= REG_RESET;
      end
      pc <= PC_RESET;
      sp <= SP_RESET;
      opcode <= 8'h00;
      immLow <= 8'h00;
      state <= ST_FETCH;
      flags <= FLAGS_RESET;
      memAddr <= 16'h0000;
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memWdata <= 8'h00;
      pcValue <= PC_RESET;
      spValue <= SP_RESET;
      accumulator <= REG_RESET;
      halted <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= next_regs[i];
      end
      pc <= next_pc;
      sp <= next_sp;
      opcode <= next_opcode;
      immLow <= next_immLow;
      state <= next_state;
      flags <= next_flags;
      memAddr <= next_memAddr;
      memRead <= next_memRead;
      memWrite <= next_memWrite;
      memWdata <= next_memWdata;
      pcValue <= next_pc;
      spValue <= next_sp;
      accumulator <= next_regs[REG_A];
      halted <= (next_state == ST_HALT);
    end
  end

  a_fetch_advance: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_FETCH) |=> (pc == $past(pc) + 16'h0001))
    else $error("Counter did not advance on fetch.");

  a_restart_target: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && opcode[7:6] == 2'b11 && opcode[2:0] == 3'h7)
      |=> (pc == {10'h000, $past(opcode[5:3]), 3'h0}))
    else $error("Restart target is wrong.");

  a_move_flags: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && opcode[7:6] == 2'b01) |=> $stable(flags))
    else $error("A move altered the flags.");

  a_flag_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state != ST_EXEC && state != ST_MEMRD) |=> $stable(flags))
    else $error("Flags changed outside completion.");

  a_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && opcode[7:6] == 2'b10 && opcode[5:3] != 3'h7)
      |=> (flags[FLAG_ZERO] == (regs[REG_A] == 8'h00)))
    else $error("Zero flag disagrees with result.");

  a_sign_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && opcode[7:6] == 2'b10 && opcode[5:3] != 3'h7)
      |=> (flags[FLAG_SIGN] == regs[REG_A][7]))
    else $error("Sign flag disagrees with result.");

  a_parity_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_EXEC && opcode[7:6] == 2'b10 && opcode[5:3] != 3'h7)
      |=> (flags[FLAG_PARITY] == ~(^regs[REG_A])))
    else $error("Parity flag disagrees with result.");

  a_jump_target: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_IMM2 && opcode == 8'hC3) |=> (pc == {$past(memData), $past(immLow)}))
    else $error("Direct jump target is wrong.");

endmodule // oaf_core
`default_nettype wire

//--- common/oaf_pkg.sv
// Purpose: Shared constants and types for the operand addressing and flag core.
// Assumes: Byte-wide memory with a 16-bit address and one-cycle read data.
// Notes:   Opcode encodings are this core's own small instruction set.
package oaf_pkg;

  localparam int ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int RESTART_SHIFT = 3;
  // Flag positions in the packed flag byte.
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_HALF = 4;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_SIGN = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Register numbers in the destination and source fields.
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  // Pair select field codes.
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_HL = 2'h2;
  localparam logic [1:0] PAIR_SP = 2'h3;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_ADC = 3'b001,
    ALU_SUB = 3'b010,
    ALU_SBB = 3'b011,
    ALU_AND = 3'b100,
    ALU_XOR = 3'b101,
    ALU_OR  = 3'b110,
    ALU_CMP = 3'b111
  } oaf_alu_type;

  typedef enum logic [3:0] {
    ST_FETCH  = 4'b0000,
    ST_DECODE = 4'b0001,
    ST_IMM1   = 4'b0010,
    ST_IMM2   = 4'b0011,
    ST_MEMRD  = 4'b0100,
    ST_MEMWR  = 4'b0101,
    ST_EXEC   = 4'b0110,
    ST_HALT   = 4'b0111
  } oaf_state_type;

endpackage : oaf_pkg

//--- verilog/oaf_alu.sv
// Purpose: Eight-bit arithmetic and logic unit with flag generation.
// Assumes: Purely combinational; the caller decides whether flags are kept.
// Notes:   Subtraction adds the two's complement so borrow is the inverted carry.
`timescale 1ns/10ps
`default_nettype none
module oaf_alu
  import oaf_pkg::*;
(
  input  wire logic [7:0]  opA,
  input  wire logic [7:0]  opB,
  input  wire oaf_alu_type aluOp,
  input  wire logic        carryIn,
  output logic      [7:0]  result,
  output logic      [7:0]  flagsOut
);

  logic [8:0] sum;
  logic [4:0] lowSum;
  logic       isSub;
  logic       cin;
  logic [7:0] opBx;
  logic       carry;
  logic       half;

  always_comb begin
    isSub = (aluOp == ALU_SUB) || (aluOp == ALU_SBB) || (aluOp == ALU_CMP);
    cin = 1'b0;
    if (aluOp == ALU_ADC) begin
      cin = carryIn;
    end else if (aluOp == ALU_SBB) begin
      cin = carryIn;
    end
    opBx = isSub ? ~opB : opB;
    sum = {1'b0, opA} + {1'b0, opBx} + {8'h00, (isSub ? ~cin : cin)};
    lowSum = {1'b0, opA[3:0]} + {1'b0, opBx[3:0]} + {4'h0, (isSub ? ~cin : cin)};
    result = sum[7:0];
    carry = isSub ? ~sum[8] : sum[8];
    half = lowSum[4];
    case (aluOp)
      ALU_AND: begin
        result = opA & opB;
        carry = 1'b0;
        half = opA[3] | opB[3];
      end
      ALU_XOR: begin
        result = opA ^ opB;
        carry = 1'b0;
        half = 1'b0;
      end
      ALU_OR: begin
        result = opA | opB;
        carry = 1'b0;
        half = 1'b0;
      end
      ALU_CMP: begin
        result = opA;
      end
      default: begin
      end
    endcase
    flagsOut = 8'h00;
    flagsOut[FLAG_CARRY] = carry;
    flagsOut[FLAG_HALF] = half;
    flagsOut[FLAG_ZERO] = (aluOp == ALU_CMP) ? (sum[7:0] == 8'h00) : (result == 8'h00);
    flagsOut[FLAG_SIGN] = (aluOp == ALU_CMP) ? sum[7] : result[7];
    flagsOut[FLAG_PARITY] = (aluOp == ALU_CMP) ? ~(^sum[7:0]) : ~(^result);
  end

endmodule // oaf_alu
`default_nettype wire

//--- testbench/oaf_mem_model.sv
// Purpose: Byte-wide program and data memory facing the core.
// Assumes: Read data is given in the cycle in which memRead is high.
// Notes:   Outside a read the data lines show the inverse of the last byte read.
`timescale 1ns/10ps
`default_nettype none
module oaf_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRead,
  input  wire logic        memWrite,
  input  wire logic [7:0]  memWdata,
  output logic      [7:0]  memData
);
  logic [7:0] store [65536];
  logic [7:0] lastData = 8'h00;

  // byte store, 16-bit address
  // A released bus changes level so that a late sample cannot pass by luck.
  assign memData = memRead ? store[memAddr] : ~lastData;

  always @(posedge clk) begin
    if (memRead) begin
      lastData <= store[memAddr];
    end
    if (memWrite) begin
      store[memAddr] <= memWdata;
    end
  end
endmodule // oaf_mem_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench for the operand addressing and flag core.
// Assumes: Programs are placed in the memory model before runProg puts the core into reset.
// Notes:   Unused memory holds the halt opcode, so a wrong jump stops at a wrong place.
`timescale 1ns/10ps
`default_nettype none
module tb
  import oaf_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  memData;
  logic [15:0] memAddr;
  logic        memRead;
  logic        memWrite;
  logic [7:0]  memWdata;
  logic [7:0]  flags;
  logic [15:0] pcValue;
  logic [15:0] spValue;
  logic [7:0]  accumulator;
  logic        halted;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cycleCount = 0;

  always #50 clk = ~clk;

  oaf_core dut (
    .clk(clk), .sys_rst(sys_rst), .memData(memData), .memAddr(memAddr),
    .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .flags(flags),
    .pcValue(pcValue), .spValue(spValue), .accumulator(accumulator), .halted(halted)
  );

  oaf_mem_model mem (
    .clk(clk), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
    .memWdata(memWdata), .memData(memData)
  );

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The ceiling is far above the thirteen short programs run here.
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end

  task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] seen);
    checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic clearMem;
    for (int a = 0; a < 65536; a++) begin
      mem.store[a] = 8'h76;
    end
  endtask

  // Bytes sit at the low end of v, the first byte highest.
  task automatic loadSeq(input logic [15:0] base, input int n, input logic [255:0] v);
    for (int i = 0; i < n; i++) begin
      mem.store[base + 16'(i)] = v[8 * (n - 1 - i) +: 8];
    end
  endtask

  task automatic runProg;
    int i;
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    chk("flags in reset", {8'h00, FLAGS_RESET}, {8'h00, flags});
    chk("pc in reset", PC_RESET, pcValue);
    sys_rst = 1'b0;
    for (i = 0; i < 400 && halted !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk("halted", 16'h0001, {15'h0000, halted});
  endtask

  task automatic aluCases;
    logic [19:0] tbl [11] = '{20'h00F01, 20'h08080, 20'h93F40, 20'h21001, 20'h20001,
                             20'hB0505, 20'h40FF8, 20'h5AAAA, 20'h68102, 20'h74242,
                             20'h74142};
    logic [2:0]  op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  res;
    logic [7:0]  acc;
    logic [7:0]  fl;
    logic [8:0]  s;
    logic [4:0]  h;
    logic        cin;
    logic        c;
    logic        bw;
    for (int k = 0; k < 11; k++) begin
      {cin, op, a, b} = tbl[k];
      h = 5'h00;
      c = 1'b0;
      bw = (op == 3'h3) ? ~cin : 1'b1;
      case (op)
        3'h0, 3'h1: begin
          s = {1'b0, a} + {1'b0, b} + {8'h00, (op == 3'h1) & cin};
          h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == 3'h1) & cin};
          res = s[7:0];
          c = s[8];
        end
        3'h4: begin
          res = a & b;
          h = {a[3] | b[3], 4'h0};
        end
        3'h5: res = a ^ b;
        3'h6: res = a | b;
        default: begin
          s = {1'b0, a} + {1'b0, ~b} + {8'h00, bw};
          h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, bw};
          res = s[7:0];
          c = ~s[8];
        end
      endcase
      fl = {res[7], res == 8'h00, 1'b0, h[4], 1'b0, ~^res, 1'b0, c};
      acc = (op == 3'h7) ? a : res;
      clearMem;
      // Preset the carry, run the operation, then a load immediate into B and a store.
      loadSeq(16'h0000, 14, 256'({8'h3E, cin ? 8'hFF : 8'h00, 8'hC6, {7'h00, cin}, 8'h3E,
              a, {2'b11, op, 3'b110}, b, 8'h06, 8'h55, 8'h32, 8'h00, 8'h20, 8'h76}));
      runProg;
      chk("alu accumulator", {8'h00, acc}, {8'h00, accumulator});
      chk("alu flags", {8'h00, fl}, {8'h00, flags});
      chk("stored result", {8'h00, acc}, {8'h00, mem.store[16'h2000]});
      chk("pc after halt", 16'h000E, pcValue);
    end
  endtask

  task automatic addrModes;
    clearMem;
    loadSeq(16'h0000, 29, 256'({24'h013412, 16'h3EA5, 8'h02, 24'h325634, 24'h3A0040,
            24'h325734, 24'h110140, 8'h1A, 24'h325834, 24'h31EFBE, 24'h214000, 8'hE9}));
    loadSeq(16'h0040, 3, 256'(24'hC30001));
    loadSeq(16'h0100, 1, 256'(8'hEF));
    loadSeq(16'h0028, 3, 256'(24'h3E9976));
    loadSeq(16'h4000, 2, 256'(16'h5AC3));
    runProg;
    chk("store via pair", 16'h00A5, {8'h00, mem.store[16'h1234]});
    chk("store direct", 16'h00A5, {8'h00, mem.store[16'h3456]});
    chk("load direct", 16'h005A, {8'h00, mem.store[16'h3457]});
    chk("load via pair", 16'h00C3, {8'h00, mem.store[16'h3458]});
    chk("stack pointer", 16'hBEEF, spValue);
    chk("restart target", 16'h002B, pcValue);
    chk("accumulator", 16'h0099, {8'h00, accumulator});
    chk("flags after moves", 16'h0000, {8'h00, flags});
  endtask

  // Memory operands through HL, register moves, then a register subtract.
  task automatic memOps;
    clearMem;
    loadSeq(16'h0000, 18, 256'({24'h210030, 16'h3681, 16'h3E01, 8'h86, 24'h320230, 8'h4E,
            8'h79, 16'h2E01, 8'h77, 8'h91, 8'h76}));
    runProg;
    chk("immediate to memory", 16'h0081, {8'h00, mem.store[16'h3000]});
    chk("add from memory", 16'h0082, {8'h00, mem.store[16'h3002]});
    chk("move via memory", 16'h0081, {8'h00, mem.store[16'h3001]});
    chk("subtract accumulator", 16'h0000, {8'h00, accumulator});
    chk("subtract flags", 16'h0054, {8'h00, flags});
    chk("pc after memory ops", 16'h0012, pcValue);
  endtask

  initial begin
    aluCases;
    addrModes;
    memOps;
    complete_run;
  end
endmodule // tb
`default_nettype wire
